// ### ppf_board_model.sv
`timescale 1ns/1ps
module ppf_board_model
  import ppf_pkg::*;
(
  input wire logic [PIN_N-1:0] padDrive,
  input wire logic [PIN_N-1:0] padEnable,
  input wire logic [PIN_N-1:0] extLevel,
  input wire logic [PIN_N-1:0] extEnable,
  output logic [PIN_N-1:0] padLevel
);
  // Wired-AND of chip and board drivers over a pull-up on every pad
  assign padLevel = (~padEnable | padDrive) & (~extEnable | extLevel);
endmodule : ppf_board_model

// ### ppf_pin_if.sv
`timescale 1ns/1ps
interface ppf_pin_if;
  import ppf_pkg::*;
  // Raw pin levels and their synchronised copies
  logic [PIN_N-1:0] pinRaw;
  logic [PIN_N-1:0] pinSync;
  modport mux (output pinRaw, input pinSync);
  modport sync (input pinRaw, output pinSync);
endinterface : ppf_pin_if

// ### ppf_pin_mux.sv
`timescale 1ns/1ps
// What this block does
// (R01) P82 is clock-run sideband when any host-bus or flash/fifo enable set.
// (R02) P81 drives gate-A20 when its enable is 1, else port pin.
// (R03) P80 drives power-event output when its enable is 1, else port pin.
// (R04) P97 is I2C0 data, drives low only; port output drives both levels.
// (R05) P97 feeds interrupt 15 when pin-select 0 and enable 1.
// (R06) P96 outputs system clock with direction 1, else sub-clock or port in.
// (R07) P95-P93 feed irq 14-12, P92-P90 feed irq 0-2 when enabled.
// (R08) PA7-PA2 are open-drain PS/2 lines when keyboard I/O enabled.
// (R09) PA7-PA0 feed key-sense inputs 15-8 when mask bit is 0.
// (R10) PA1/PA0 are open-drain I2C1 clock/data when channel enabled.
// (R11) PB7: flash slave select, else request-to-send, else port pin.
// (R12) PB5: flash data input, else data-terminal-ready, else port pin.
// (R13) PB6: flash clock out; clear-to-send input with fifo on, select 0.
// (R14) PB4: flash data out; data-set-ready input with fifo on, select 0.
// (R15) PB3 drives PWM1 with direction and enable; carrier-detect samples pin.
// (R16) PB2 drives PWM0 when enabled, count modes 0; ring sense samples.
// (R17) PB1 drives system-control interrupt when its enable is 1.
// (R18) PB0 drives system-management interrupt when its enable is 1.
// (R19) PC7 drives timer2 B on output setting; ext clock D on code 7/phase.
// (R20) PC7 feeds timer2 capture B in normal or phase mode with top bit.
// (R21) PC6 drives timer2 A on output setting; feeds capture A likewise.
// (R22) PC7/PC6 feed wake-up inputs 15/14 when mask bit is 0.
// (R23) Port mode: direction 0 is input, 1 drives the port data latch.
module ppf_pin_mux
  import ppf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  // Pads
  input wire logic [PIN_N-1:0] pinIn,
  output logic [PIN_N-1:0] pinOut_ff,
  output logic [PIN_N-1:0] pinOe_ff,
  // Port data latch, direction and read-back
  input wire logic [PIN_N-1:0] portData,
  input wire logic [PIN_N-1:0] portDir,
  output logic [PIN_N-1:0] portRead_ff,
  // Host bus sideband
  input wire logic flashIfHostEnable,
  input wire logic serialFifoEnable,
  input wire logic hostChanAEnable,
  input wire logic hostChan4Enable,
  input wire logic [2:0] hostChanEnable,
  output logic hostBusAnyEnable_ff,
  input wire logic clockRunOut,
  input wire logic clockRunOe,
  output logic clockRunIn_ff,
  input wire logic gateA20Enable,
  input wire logic gateA20Out,
  input wire logic powerEventEnable,
  input wire logic powerEventOut,
  input wire logic sysCtrlIrqEnable,
  input wire logic sysCtrlIrqOut,
  input wire logic sysMgmtIrqEnable,
  input wire logic sysMgmtIrqOut,
  // I2C channels
  input wire logic [1:0] i2cBusEnable,
  input wire logic i2c0DataLevel,
  input wire logic i2c1ClockLevel,
  input wire logic i2c1DataLevel,
  output logic i2c0DataLine_ff,
  output logic i2c1ClockLine_ff,
  output logic i2c1DataLine_ff,
  // External interrupts
  input wire logic [3:0] irqPinSelect,
  input wire logic [3:0] irqHighEnable,
  input wire logic [2:0] irqLowEnable,
  output logic [3:0] irqHighIn_ff,
  output logic [2:0] irqLowIn_ff,
  // Clock pin
  input wire logic sysClockLevel,
  input wire logic extSubclockSelect,
  input wire logic extSubclockEnable,
  output logic extSubclockIn_ff,
  // Keyboard
  input wire logic keyboardIoEnable,
  input wire logic [PS2_LINES-1:0] ps2LineLevel,
  input wire logic [7:0] keyIrqMaskBit,
  output logic [7:0] keySenseInput_ff,
  // Flash interface
  input wire logic flashIfEnable,
  input wire logic flashIfSlaveSelect,
  input wire logic flashIfClockOut,
  input wire logic flashIfDataOut,
  output logic flashIfDataIn_ff,
  // Serial modem lines
  input wire logic serialFifoOutSel1,
  input wire logic serialFifoOutSel0,
  input wire logic extSerialSelect,
  input wire logic requestToSend,
  input wire logic dataTermReady,
  output logic clearToSend_ff,
  output logic dataSetReady_ff,
  output logic carrierDetect_ff,
  output logic ringIndicator_ff,
  // PWM
  input wire logic pwmCh1OutEnable,
  input wire logic pwmCh0OutEnable,
  input wire logic pwm01CountModeA,
  input wire logic pwm01CountModeB,
  input wire logic pwmCh1Out,
  input wire logic pwmCh0Out,
  // Timer channel 2
  input wire logic timer2OutSetA,
  input wire logic timer2OutSetB,
  input wire logic timer2OutA,
  input wire logic timer2OutB,
  input wire logic timer2NormalMode,
  input wire logic timer2PhaseMode,
  input wire logic [2:0] timerPrescaleSelect,
  input wire logic timer2AIoCtrlTop,
  input wire logic timer2BIoCtrlTop,
  output logic timer2IoA_ff,
  output logic timer2IoB_ff,
  output logic timerExtClockD_ff,
  // Wake-up events 15/14
  input wire logic [1:0] wakeupMask,
  output logic [1:0] wakeupInput_ff
);

  // Pad bundle shared with the synchroniser
  ppf_pin_if pins ();

  // Synchronised pad levels
  logic [PIN_N-1:0] s;
  logic [PIN_N-1:0] nxtOut;
  logic [PIN_N-1:0] nxtOe;
  logic hostBusAny;
  logic fifoOutEnable;
  logic pwm0OutEnable;

  // Pads enter through the synchroniser
  assign pins.pinRaw = pinIn;
  assign s = pins.pinSync;

  ppf_pin_sync uSync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pins(pins.sync)
  );

  // Combined enables
  assign hostBusAny = flashIfHostEnable | serialFifoEnable |
    hostChanAEnable | hostChan4Enable | (|hostChanEnable); // R01
  assign fifoOutEnable = (serialFifoEnable & serialFifoOutSel1 &
    serialFifoOutSel0 | serialFifoEnable & serialFifoOutSel0) &
    extSerialSelect; // R11 R12
  assign pwm0OutEnable = pwmCh0OutEnable & ~pwm01CountModeA &
    ~pwm01CountModeB; // R16

  // Output drive per pin
  always_comb begin
    nxtOe = portDir; // R23
    nxtOut = portData; // R23
    // Port 8
    if (hostBusAny) begin
      nxtOe[P8_BASE+2] = clockRunOe; // R01
      nxtOut[P8_BASE+2] = clockRunOut; // R01
    end
    if (gateA20Enable) begin
      nxtOe[P8_BASE+1] = 1'h1; // R02
      nxtOut[P8_BASE+1] = gateA20Out; // R02
    end
    if (powerEventEnable) begin
      nxtOe[P8_BASE] = 1'h1; // R03
      nxtOut[P8_BASE] = powerEventOut; // R03
    end
    // Port 9
    // Open drain: enable only for a low level, else pull-up
    if (i2cBusEnable[0]) begin
      nxtOe[P9_BASE+7] = ~i2c0DataLevel; // R04
      nxtOut[P9_BASE+7] = 1'h0; // R04
    end
    if (portDir[P9_BASE+6]) begin
      nxtOe[P9_BASE+6] = 1'h1; // R06
      nxtOut[P9_BASE+6] = sysClockLevel; // R06
    end
    // Port A
    // PS/2 lines are open drain like the I2C pins
    for (int k = 0; k < PS2_LINES; k++) begin
      if (keyboardIoEnable) begin
        nxtOe[PA_BASE+PS2_FIRST+k] = ~ps2LineLevel[k]; // R08
        nxtOut[PA_BASE+PS2_FIRST+k] = 1'h0; // R08
      end
    end
    if (i2cBusEnable[1]) begin
      nxtOe[PA_BASE+1] = ~i2c1ClockLevel; // R10
      nxtOut[PA_BASE+1] = 1'h0; // R10
      nxtOe[PA_BASE] = ~i2c1DataLevel; // R10
      nxtOut[PA_BASE] = 1'h0; // R10
    end
    // Port B, flash interface first
    // Flash wins over the modem outputs on PB7 and PB5
    if (flashIfEnable) begin
      nxtOe[PB_BASE+7] = 1'h1; // R11
      nxtOut[PB_BASE+7] = flashIfSlaveSelect; // R11
      nxtOe[PB_BASE+6] = 1'h1; // R13
      nxtOut[PB_BASE+6] = flashIfClockOut; // R13
      nxtOe[PB_BASE+5] = 1'h0; // R12
      nxtOut[PB_BASE+5] = 1'h0; // R12
      nxtOe[PB_BASE+4] = 1'h1; // R14
      nxtOut[PB_BASE+4] = flashIfDataOut; // R14
    end else if (fifoOutEnable) begin
      nxtOe[PB_BASE+7] = 1'h1; // R11
      nxtOut[PB_BASE+7] = requestToSend; // R11
      nxtOe[PB_BASE+5] = 1'h1; // R12
      nxtOut[PB_BASE+5] = dataTermReady; // R12
    end
    // PWM replaces the value only; enable stays with direction
    if (portDir[PB_BASE+3] && pwmCh1OutEnable) begin
      nxtOut[PB_BASE+3] = pwmCh1Out; // R15
    end
    if (portDir[PB_BASE+2] && pwm0OutEnable) begin
      nxtOut[PB_BASE+2] = pwmCh0Out; // R16
    end
    if (sysCtrlIrqEnable) begin
      nxtOe[PB_BASE+1] = 1'h1; // R17
      nxtOut[PB_BASE+1] = sysCtrlIrqOut; // R17
    end
    if (sysMgmtIrqEnable) begin
      nxtOe[PB_BASE] = 1'h1; // R18
      nxtOut[PB_BASE] = sysMgmtIrqOut; // R18
    end
    // Port C, timer channel 2 outputs
    if (timer2OutSetB) begin
      nxtOe[PC_BASE+1] = 1'h1; // R19
      nxtOut[PC_BASE+1] = timer2OutB; // R19
    end
    if (timer2OutSetA) begin
      nxtOe[PC_BASE] = 1'h1; // R21
      nxtOut[PC_BASE] = timer2OutA; // R21
    end
  end

  // Pad drive registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinOut_ff <= PIN_RST;
      pinOe_ff <= PIN_RST;
      portRead_ff <= PIN_RST;
      hostBusAnyEnable_ff <= IDLE_ACT_HIGH;
    end else begin
      pinOut_ff <= nxtOut;
      pinOe_ff <= nxtOe;
      portRead_ff <= s;
      hostBusAnyEnable_ff <= hostBusAny;
    end
  end

  // Host bus and I2C inputs, idle high when not selected
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clockRunIn_ff <= IDLE_ACT_LOW;
      i2c0DataLine_ff <= IDLE_ACT_LOW;
      i2c1ClockLine_ff <= IDLE_ACT_LOW;
      i2c1DataLine_ff <= IDLE_ACT_LOW;
    end else begin
      clockRunIn_ff <= hostBusAny ? s[P8_BASE+2] : IDLE_ACT_LOW; // R01
      i2c0DataLine_ff <= i2cBusEnable[0] ? s[P9_BASE+7] : IDLE_ACT_LOW;
      i2c1ClockLine_ff <= i2cBusEnable[1] ? s[PA_BASE+1] : IDLE_ACT_LOW;
      i2c1DataLine_ff <= i2cBusEnable[1] ? s[PA_BASE] : IDLE_ACT_LOW;
    end
  end

  // External interrupt and key-sense inputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqHighIn_ff <= 4'hf;
      irqLowIn_ff <= 3'h7;
      keySenseInput_ff <= 8'hff;
    end else begin
      // Irq 12 to 14 from P93 to P95
      for (int k = 0; k < 3; k++) begin
        irqHighIn_ff[k] <= (!irqPinSelect[k] && irqHighEnable[k]) ?
          s[P9_BASE+3+k] : IDLE_ACT_LOW; // R07
      end
      // Irq 15 shares P97 with I2C channel 0 data
      irqHighIn_ff[3] <= (!irqPinSelect[3] && irqHighEnable[3]) ?
        s[P9_BASE+7] : IDLE_ACT_LOW; // R05
      // Irq 0 to 2 from P92 down to P90
      for (int k = 0; k < 3; k++) begin
        irqLowIn_ff[k] <= irqLowEnable[k] ?
          s[P9_BASE+2-k] : IDLE_ACT_LOW; // R07
      end
      for (int k = 0; k < 8; k++) begin
        keySenseInput_ff[k] <= keyIrqMaskBit[k] ?
          IDLE_ACT_LOW : s[PA_BASE+k]; // R09
      end
    end
  end

  // Sub-clock input on P96
  // Only while the pin is not driving the system clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      extSubclockIn_ff <= IDLE_ACT_HIGH;
    end else begin
      extSubclockIn_ff <= (!portDir[P9_BASE+6] && !extSubclockSelect &&
        extSubclockEnable) ? s[P9_BASE+6] : IDLE_ACT_HIGH; // R06
    end
  end

  // Flash data and modem status inputs on port B
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flashIfDataIn_ff <= IDLE_ACT_HIGH;
      clearToSend_ff <= IDLE_ACT_LOW;
      dataSetReady_ff <= IDLE_ACT_LOW;
      carrierDetect_ff <= IDLE_ACT_LOW;
      ringIndicator_ff <= IDLE_ACT_LOW;
    end else begin
      flashIfDataIn_ff <= flashIfEnable ? s[PB_BASE+5] : IDLE_ACT_HIGH;
      clearToSend_ff <= (serialFifoEnable && !extSerialSelect) ?
        s[PB_BASE+6] : IDLE_ACT_LOW; // R13
      dataSetReady_ff <= (serialFifoEnable && !extSerialSelect) ?
        s[PB_BASE+4] : IDLE_ACT_LOW; // R14
      carrierDetect_ff <= s[PB_BASE+3]; // R15
      ringIndicator_ff <= s[PB_BASE+2]; // R16
    end
  end

  // Timer channel 2 inputs and wake-up events
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer2IoA_ff <= IDLE_ACT_HIGH;
      timer2IoB_ff <= IDLE_ACT_HIGH;
      timerExtClockD_ff <= IDLE_ACT_HIGH;
      wakeupInput_ff <= 2'h3;
    end else begin
      // Clock D by prescaler code or phase counting
      timerExtClockD_ff <= (timerPrescaleSelect == PRESCALE_EXT_D ||
        timer2PhaseMode) ? s[PC_BASE+1] : IDLE_ACT_HIGH; // R19
      timer2IoB_ff <= (timer2NormalMode || (timer2PhaseMode &&
        timer2BIoCtrlTop)) ? s[PC_BASE+1] : IDLE_ACT_HIGH; // R20
      timer2IoA_ff <= (timer2NormalMode || (timer2PhaseMode &&
        timer2AIoCtrlTop)) ? s[PC_BASE] : IDLE_ACT_HIGH; // R21
      // Wake-up 15 on PC7, 14 on PC6
      wakeupInput_ff[1] <= wakeupMask[1] ? IDLE_ACT_LOW : s[PC_BASE+1];
      wakeupInput_ff[0] <= wakeupMask[0] ? IDLE_ACT_LOW : s[PC_BASE]; // R22
    end
  end

endmodule : ppf_pin_mux

// ### ppf_pin_mux_sva.sv
`timescale 1ns/1ps
module ppf_pin_mux_sva
  import ppf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [PIN_N-1:0] pinIn,
  input wire logic [PIN_N-1:0] pinOut_ff,
  input wire logic [PIN_N-1:0] pinOe_ff,
  input wire logic [PIN_N-1:0] portData,
  input wire logic [PIN_N-1:0] portDir,
  input wire logic gateA20Enable,
  input wire logic gateA20Out,
  input wire logic powerEventEnable,
  input wire logic powerEventOut,
  input wire logic [1:0] i2cBusEnable,
  input wire logic i2c0DataLevel,
  input wire logic keyboardIoEnable,
  input wire logic [5:0] ps2LineLevel,
  input wire logic flashIfEnable,
  input wire logic flashIfSlaveSelect,
  input wire logic [1:0] wakeupMask,
  input wire logic [1:0] wakeupInput_ff,
  input wire logic carrierDetect_ff
);
  logic [1:0] upCnt_ff;
  // Edges since reset release, saturating at 3
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) upCnt_ff <= 2'h0;
    else if (upCnt_ff != 2'h3) upCnt_ff <= upCnt_ff + 2'h1;
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Pad drive follows its selects one edge later
  a_gate_drive: assert property (
    upCnt_ff != 2'h0 && $past(gateA20Enable) |->
    pinOe_ff[1] && pinOut_ff[1] == $past(gateA20Out)) else $error("gate");
  a_event_drive: assert property (
    upCnt_ff != 2'h0 && $past(powerEventEnable) |->
    pinOe_ff[0] && pinOut_ff[0] == $past(powerEventOut)) else $error("event");
  a_port_follow: assert property (
    upCnt_ff != 2'h0 && !$past(gateA20Enable) |->
    pinOe_ff[1] == $past(portDir[1]) &&
    (!pinOe_ff[1] || pinOut_ff[1] == $past(portData[1]))) else $error("port");
  a_i2c_low_only: assert property (
    upCnt_ff != 2'h0 && $past(i2cBusEnable[0]) |->
    !pinOut_ff[10] && pinOe_ff[10] == !$past(i2c0DataLevel)) else $error("i2c");
  a_kbd_low_only: assert property (
    upCnt_ff != 2'h0 && $past(keyboardIoEnable) |-> pinOut_ff[18:13] == 6'h00
    && pinOe_ff[18:13] == ~$past(ps2LineLevel)) else $error("kbd lines");
  a_flash_select: assert property (
    upCnt_ff != 2'h0 && $past(flashIfEnable) |->
    pinOe_ff[26] && pinOut_ff[26] == $past(flashIfSlaveSelect))
    else $error("flash select");
  // Pad sense path is three edges deep
  a_wake_sense: assert property (
    upCnt_ff == 2'h3 && !$past(wakeupMask[1]) |->
    wakeupInput_ff[1] == $past(pinIn[28], 3)) else $error("wake");
  a_carrier_sense: assert property (
    upCnt_ff == 2'h3 |-> carrierDetect_ff == $past(pinIn[22], 3))
    else $error("carrier");
endmodule : ppf_pin_mux_sva

bind ppf_pin_mux ppf_pin_mux_sva ppf_pin_mux_sva_inst (.*);

// ### ppf_pin_sync.sv
`timescale 1ns/1ps
module ppf_pin_sync
  import ppf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  ppf_pin_if.sync pins
);

  genvar i;
  // Two flip-flops per pin; first stage feeds only the second
  generate
    for (i = 0; i < PIN_N; i++) begin : gSync
      logic [SYNC_STAGES-1:0] stage_ff;
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          stage_ff <= 2'h0;
        end else begin
          stage_ff <= {stage_ff[0], pins.pinRaw[i]};
        end
      end
      assign pins.pinSync[i] = stage_ff[SYNC_STAGES-1];
    end
  endgenerate

endmodule : ppf_pin_sync

// ### ppf_pkg.sv
package ppf_pkg;
  // Pin vector layout: P80..P82, P90..P97, PA0..PA7, PB0..PB7, PC6..PC7
  localparam int PIN_N = 29;
  localparam int P8_BASE = 0;
  localparam int P9_BASE = 3;
  localparam int PA_BASE = 11;
  localparam int PB_BASE = 19;
  localparam int PC_BASE = 27;
  localparam int PS2_LINES = 6;
  localparam int PS2_FIRST = 2;
  // Input synchroniser depth
  localparam int SYNC_STAGES = 2;
  // Prescaler code that picks external clock D
  localparam logic [2:0] PRESCALE_EXT_D = 3'h7;
  // Reset values
  localparam logic [PIN_N-1:0] PIN_RST = 29'h0000000;
  localparam logic IDLE_ACT_LOW = 1'h1;
  localparam logic IDLE_ACT_HIGH = 1'h0;
endpackage : ppf_pkg

// ### test_ppf_pin_mux.sv
`timescale 1ns/1ps
module test_ppf_pin_mux import ppf_pkg::*;;
  bit ref_clk;
  bit rst = 1'h1;
  bit [PIN_N-1:0] portData, portDir, extLevel, extEnable;
  bit flashIfHostEnable, serialFifoEnable, hostChanAEnable, hostChan4Enable;
  bit clockRunOut, clockRunOe, gateA20Enable, gateA20Out, powerEventEnable;
  bit powerEventOut, sysCtrlIrqEnable, sysCtrlIrqOut, sysMgmtIrqEnable;
  bit sysMgmtIrqOut, i2c0DataLevel, i2c1ClockLevel, i2c1DataLevel;
  bit sysClockLevel, extSubclockSelect, extSubclockEnable, keyboardIoEnable;
  bit flashIfEnable, flashIfSlaveSelect, flashIfClockOut, flashIfDataOut;
  bit serialFifoOutSel1, serialFifoOutSel0, extSerialSelect, requestToSend;
  bit dataTermReady, pwmCh1OutEnable, pwmCh0OutEnable, pwm01CountModeA;
  bit pwm01CountModeB, pwmCh1Out, pwmCh0Out, timer2OutSetA, timer2OutSetB;
  bit timer2OutA, timer2OutB, timer2NormalMode, timer2PhaseMode;
  bit timer2AIoCtrlTop, timer2BIoCtrlTop;
  bit [2:0] hostChanEnable, irqLowEnable, timerPrescaleSelect;
  bit [1:0] i2cBusEnable, wakeupMask;
  bit [3:0] irqPinSelect, irqHighEnable;
  bit [5:0] ps2LineLevel;
  bit [7:0] keyIrqMaskBit;
  logic [PIN_N-1:0] pinIn, pinOut_ff, pinOe_ff, portRead_ff;
  logic hostBusAnyEnable_ff, clockRunIn_ff, i2c0DataLine_ff, i2c1ClockLine_ff;
  logic i2c1DataLine_ff, extSubclockIn_ff, flashIfDataIn_ff, clearToSend_ff;
  logic dataSetReady_ff, carrierDetect_ff, ringIndicator_ff, timer2IoA_ff;
  logic timer2IoB_ff, timerExtClockD_ff;
  logic [3:0] irqHighIn_ff;
  logic [2:0] irqLowIn_ff;
  logic [7:0] keySenseInput_ff;
  logic [1:0] wakeupInput_ff;
  int fails, cmp_count;

  ppf_pin_mux ppf_pin_mux_inst (.*);
  ppf_board_model ppf_board_model_inst (.padDrive(pinOut_ff),
    .padEnable(pinOe_ff), .extLevel(extLevel), .extEnable(extEnable),
    .padLevel(pinIn));

  // Clock generator
  always #20 ref_clk = ~ref_clk;

  task automatic chk(input string nm, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Wait out the three-edge sense path
  task automatic settle;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic sc_port;
    #1;
    chk("oe reset", 32'h0, pinOe_ff);
    @(posedge ref_clk);
    portDir <= 29'h2;
    portData <= 29'h3;
    extEnable[0] <= 1'h1;
    settle;
    chk("port oe", 32'h2, pinOe_ff[2:0]);
    chk("port out", 32'h1, pinOut_ff[1]);
    chk("port read", 32'h6, portRead_ff[2:0]);
  endtask : sc_port

  task automatic sc_host;
    @(posedge ref_clk);
    extEnable <= 29'h0;
    portData <= 29'h0;
    portDir[9] <= 1'h1;
    sysClockLevel <= 1'h1;
    {gateA20Enable, powerEventEnable, sysCtrlIrqEnable, sysMgmtIrqEnable} <= 4'hf;
    {gateA20Out, powerEventOut, sysCtrlIrqOut, sysMgmtIrqOut} <= 4'ha;
    settle;
    chk("p8 drive", 32'he, {pinOe_ff[1:0], pinOut_ff[1:0]});
    chk("host irq", 32'he, {pinOe_ff[20:19], pinOut_ff[20:19]});
    chk("clock pin", 32'h3, {pinOe_ff[9], pinOut_ff[9]});
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk);
      {flashIfHostEnable, serialFifoEnable, hostChanAEnable, hostChan4Enable,
        hostChanEnable} <= 7'h1 << i;
      clockRunOe <= 1'h1;
      settle;
      chk("host any", 32'h3, {hostBusAnyEnable_ff, pinOe_ff[2]});
    end
  endtask : sc_host

  task automatic sc_i2c;
    @(posedge ref_clk);
    {flashIfHostEnable, serialFifoEnable} <= 2'h0;
    {portDir[10], portData[10]} <= 2'h3;
    i2cBusEnable <= 2'h1;
    irqHighEnable <= 4'h8;
    settle;
    chk("i2c pull low", 32'h4, {pinOe_ff[10], pinOut_ff[10], irqHighIn_ff[3]});
    @(posedge ref_clk);
    i2c0DataLevel <= 1'h1;
    settle;
    chk("i2c release", 32'h3, {pinOe_ff[10], i2c0DataLine_ff, irqHighIn_ff[3]});
  endtask : sc_i2c

  task automatic sc_keyboard;
    @(posedge ref_clk);
    keyboardIoEnable <= 1'h1;
    ps2LineLevel <= 6'h2a;
    settle;
    chk("kbd oe", 32'h15, pinOe_ff[18:13]);
    chk("kbd out", 32'h0, pinOut_ff[18:13]);
    chk("key sense", 32'hab, keySenseInput_ff);
    @(posedge ref_clk);
    keyIrqMaskBit <= 8'hf0;
    settle;
    chk("key masked", 32'hfb, keySenseInput_ff);
  endtask : sc_keyboard

  task automatic sc_serial;
    @(posedge ref_clk);
    {flashIfEnable, flashIfSlaveSelect, serialFifoEnable} <= 3'h7;
    {serialFifoOutSel0, extSerialSelect, dataTermReady} <= 3'h7;
    settle;
    chk("flash ss", 32'h3, {pinOe_ff[26], pinOut_ff[26]});
    chk("flash di", 32'h0, pinOe_ff[24]);
    @(posedge ref_clk);
    flashIfEnable <= 1'h0;
    settle;
    chk("rts", 32'h2, {pinOe_ff[26], pinOut_ff[26]});
    chk("dtr", 32'h3, {pinOe_ff[24], pinOut_ff[24]});
    @(posedge ref_clk);
    extSerialSelect <= 1'h0;
    extEnable[25] <= 1'h1;
    settle;
    chk("cts dsr", 32'h1, {clearToSend_ff, dataSetReady_ff});
  endtask : sc_serial

  task automatic sc_timer;
    @(posedge ref_clk);
    portDir[22:21] <= 2'h3;
    {pwmCh1OutEnable, pwmCh0OutEnable, pwm01CountModeA} <= 3'h7;
    {pwmCh1Out, pwmCh0Out} <= 2'h3;
    {timer2OutSetB, timer2OutB, timer2NormalMode} <= 3'h7;
    extEnable[27] <= 1'h1;
    settle;
    chk("pwm out", 32'h2, pinOut_ff[22:21]);
    chk("dcd ri", 32'h2, {carrierDetect_ff, ringIndicator_ff});
    chk("timer b", 32'h6, {pinOe_ff[28], timer2IoB_ff, timer2IoA_ff});
    chk("wake", 32'h2, wakeupInput_ff);
  endtask : sc_timer

  task automatic sc_inputs;
    @(posedge ref_clk);
    extEnable <= 29'h148;
    portDir[9] <= 1'h0;
    {extSubclockEnable, irqHighEnable, irqLowEnable} <= 8'hff;
    {i2cBusEnable, i2c1ClockLevel, i2c1DataLevel, clockRunOut} <= 5'h1a;
    {timer2NormalMode, timer2PhaseMode, timer2AIoCtrlTop} <= 3'h3;
    {timer2OutSetA, timer2OutA, pwm01CountModeA} <= 3'h6;
    {flashIfEnable, flashIfClockOut, flashIfDataOut} <= 3'h6;
    settle;
    chk("irq pins", 32'h53, {irqHighIn_ff, irqLowIn_ff});
    chk("sub clock", 32'h1, {pinOe_ff[9], extSubclockIn_ff});
    chk("i2c1 drive", 32'h8, {pinOe_ff[12:11], pinOut_ff[12:11]});
    chk("i2c1 sense", 32'h1, {i2c1ClockLine_ff, i2c1DataLine_ff});
    chk("clock run", 32'h4, {pinOe_ff[2], pinOut_ff[2], clockRunIn_ff});
    chk("timer a out", 32'h3, {pinOe_ff[27], pinOut_ff[27]});
    chk("timer phase", 32'h5, {timerExtClockD_ff, timer2IoB_ff, timer2IoA_ff});
    chk("flash ck", 32'h3, {pinOe_ff[25], pinOut_ff[25]});
    chk("flash do", 32'h2, {pinOe_ff[23], pinOut_ff[23]});
    chk("flash data in", 32'h1, flashIfDataIn_ff);
    chk("pwm0 out", 32'h3, pinOut_ff[22:21]);
    @(posedge ref_clk);
    {extSubclockSelect, irqPinSelect, irqLowEnable} <= 8'h8b;
    {timerPrescaleSelect, timer2PhaseMode} <= 4'he;
    settle;
    chk("irq select", 32'h5f, {irqHighIn_ff, irqLowIn_ff});
    chk("sub clock off", 32'h0, extSubclockIn_ff);
    chk("clock d", 32'h4, {timerExtClockD_ff, timer2IoB_ff, timer2IoA_ff});
  endtask : sc_inputs

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // Hang guard
  initial begin
    #100000;
    fails++;
    final_report;
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    sc_port;
    sc_host;
    sc_i2c;
    sc_keyboard;
    sc_serial;
    sc_timer;
    sc_inputs;
    final_report;
  end
endmodule : test_ppf_pin_mux
